// >>> verilog/bit_ops_call_return_exec.sv
/*
  Execution unit for single-bit carry logic, bit force, call, break and return.
  Software loads core state and commands over AXI4-Lite; data and stack go over a
  same-clock memory port whose ready input inserts wait states.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module bit_ops_call_return_exec
  import bit_ops_call_return_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Data memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rdy,
  // Status
  output logic             exec_busy
);

  // ==========================================================================
  // State
  op_e         op_q;
  kind_e       kind_q;
  logic [2:0]  bit_q;
  logic [15:0] operand_q;
  logic [15:0] program_counter_q;
  logic [15:0] stack_pointer_q;
  logic [7:0]  status_word_q;
  logic [7:0]  acc_q;
  logic [15:0] pointer_pair_q;
  logic        busy_q;
  logic [2:0]  step_q;
  logic [3:0]  cnt_q;
  logic [7:0]  elapsed_q;
  logic [7:0]  last_cyc_q;
  logic [7:0]  cap_q [0:4];
  logic        mem_req_q, mem_we_q;
  logic [15:0] mem_addr_q;
  logic [7:0]  mem_wdata_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_full_q, w_full_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ==========================================================================
  // Decode and sequencing terms
  logic        stall, completing, fin, launch, wr_fire, mem_kind, hs, src_bit;
  logic [2:0]  idx, nsteps;
  logic [3:0]  base;
  logic [15:0] daddr, ret_addr, ilen;
  logic [7:0]  cap_w [0:4];
  logic [7:0]  mask, mod_byte;
  logic        a_vld, a_we;
  logic [15:0] a_addr;
  logic [7:0]  a_wd;
  logic [31:0] wr_val;
  logic        wr_ok;

  // Memory handshake: a pending access not yet ready is a wait cycle
  assign stall      = mem_req_q && !mem_rdy; // RULE19
  assign completing = mem_req_q && mem_rdy;
  assign idx        = completing ? step_q + 3'h1 : step_q;
  assign mem_kind   = (kind_q != KIND_ACC) && (kind_q != KIND_STATUS_WORD);
  assign daddr      = (kind_q == KIND_POINTER_PAIR) ? pointer_pair_q : operand_q;
  assign mask       = 8'h01 << bit_q;
  assign wr_fire    = aw_full_q && w_full_q && !bvalid_q;
  assign launch     = wr_fire && (aw_addr_q == OFS_CMD) && !busy_q;

  // Read data forwarded in the cycle an access completes
  for (genvar i = 0; i < 5; i++) begin : g_cap
    assign cap_w[i] = (completing && step_q == 3'(i)) ? mem_rdata : cap_q[i];
  end

  assign mod_byte = (op_q == OP_FORCE_ONE) ? (cap_w[0] | mask) : (cap_w[0] & ~mask);

  // Area, base cycle count, access count and length
  always_comb begin
    hs = 1'b1;
    if ((op_q <= OP_FORCE_ZERO) && mem_kind) begin
      hs = (daddr >= HS_RAM_LO) && (daddr <= HS_RAM_HI); // RULE2 RULE3
    end
    base   = CYC_OTHER;
    nsteps = 3'h0;
    ilen   = LEN_1;
    case (op_q)
      OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR: begin
        nsteps = mem_kind ? 3'h1 : 3'h0;
        ilen   = ((kind_q == KIND_ACC) || (kind_q == KIND_POINTER_PAIR)) ? LEN_2 : LEN_3;
        if (kind_q == KIND_ACC) base = CYC_ACC; // RULE10
        else if (kind_q == KIND_SFR || kind_q == KIND_STATUS_WORD) base = CYC_LOG_EXT;
        else base = hs ? CYC_LOG_HS : CYC_LOG_EXT; // RULE9
      end
      OP_FORCE_ONE, OP_FORCE_ZERO: begin
        nsteps = mem_kind ? 3'h2 : 3'h0;
        ilen   = (kind_q == KIND_SFR) ? LEN_3 : LEN_2;
        case (kind_q)
          KIND_SHORT_DIRECT: base = hs ? CYC_FRC_SHORT_HS : CYC_FRC_SHORT_EX;
          KIND_SFR:          base = CYC_FRC_SFR;
          KIND_ACC:          base = CYC_ACC;
          KIND_STATUS_WORD:  base = CYC_FRC_SW;
          default:           base = hs ? CYC_FRC_PTR_HS : CYC_FRC_PTR_EX; // RULE11 RULE12
        endcase
      end
      OP_CARRY_ONE, OP_CARRY_ZERO, OP_CARRY_COMPLEMENT: base = CYC_CARRY;
      OP_CALL:              begin base = CYC_CALL;       nsteps = 3'h2; ilen = LEN_3; end
      OP_FIXED_AREA_CALL:   begin base = CYC_FIXED_CALL; nsteps = 3'h2; ilen = LEN_2; end
      OP_TABLE_CALL:        begin base = CYC_TABLE_CALL; nsteps = 3'h4; end
      OP_SOFTWARE_BREAK:    begin base = CYC_BREAK;      nsteps = 3'h5; end
      OP_SUBROUTINE_RETURN: begin base = CYC_RETURN;     nsteps = 3'h2; end
      default:              base = CYC_OTHER;
    endcase
  end

  assign ret_addr = program_counter_q + ilen;
  // Waits freeze the counter, so they add one cycle each on top of base
  assign fin = busy_q && !stall && (cnt_q >= base - 4'h1) && (idx == nsteps); // RULE1 RULE4 RULE5

  // Memory access for sequence position idx
  always_comb begin
    a_vld  = 1'b0;
    a_we   = 1'b0;
    a_addr = daddr;
    a_wd   = 8'h00;
    case (op_q)
      OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR: a_vld = mem_kind && (idx == 3'h0);
      OP_FORCE_ONE, OP_FORCE_ZERO: begin
        a_vld = mem_kind && (idx <= 3'h1);
        a_we  = (idx == 3'h1);  // RULE11 RULE12
        a_wd  = mod_byte;
      end
      OP_CALL, OP_FIXED_AREA_CALL, OP_TABLE_CALL: begin
        case (idx)
          3'h0: begin a_vld = 1'b1; a_we = 1'b1; a_addr = stack_pointer_q - 16'h0001;
                      a_wd = ret_addr[15:8]; end // RULE13 RULE14 RULE15
          3'h1: begin a_vld = 1'b1; a_we = 1'b1; a_addr = stack_pointer_q - 16'h0002;
                      a_wd = ret_addr[7:0]; end
          3'h2: begin a_vld = (op_q == OP_TABLE_CALL); a_addr = {11'h000, operand_q[4:0]}; end
          3'h3: begin a_vld = (op_q == OP_TABLE_CALL);
                      a_addr = {11'h000, operand_q[4:0]} + 16'h0001; end
          default: a_vld = 1'b0;
        endcase
      end
      OP_SOFTWARE_BREAK: begin
        case (idx)
          3'h0: begin a_vld = 1'b1; a_we = 1'b1; a_addr = stack_pointer_q - 16'h0001;
                      a_wd = status_word_q; end // RULE16
          3'h1: begin a_vld = 1'b1; a_we = 1'b1; a_addr = stack_pointer_q - 16'h0002;
                      a_wd = ret_addr[15:8]; end
          3'h2: begin a_vld = 1'b1; a_we = 1'b1; a_addr = stack_pointer_q - 16'h0003;
                      a_wd = ret_addr[7:0]; end
          3'h3: begin a_vld = 1'b1; a_addr = VEC_HIGH_ADDR; end
          3'h4: begin a_vld = 1'b1; a_addr = VEC_LOW_ADDR; end
          default: a_vld = 1'b0;
        endcase
      end
      OP_SUBROUTINE_RETURN: begin
        a_vld  = (idx <= 3'h1); // RULE17
        a_addr = (idx == 3'h0) ? stack_pointer_q : stack_pointer_q + 16'h0001;
      end
      default: a_vld = 1'b0;
    endcase
  end

  // Chosen operand bit
  always_comb begin
    case (kind_q)
      KIND_ACC:         src_bit = acc_q[bit_q];
      KIND_STATUS_WORD: src_bit = status_word_q[bit_q];
      default:          src_bit = cap_w[0][bit_q];
    endcase
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q     <= 1'b0;
      step_q     <= 3'h0;
      cnt_q      <= 4'h0;
      elapsed_q  <= 8'h00;
      last_cyc_q <= 8'h00;
    end else if (ce) begin
      if (launch) begin
        busy_q    <= 1'b1;
        step_q    <= 3'h0;
        cnt_q     <= 4'h0;
        elapsed_q <= 8'h00;
      end else if (busy_q) begin
        elapsed_q <= elapsed_q + 8'h01;
        if (completing) step_q <= step_q + 3'h1;
        if (!stall) cnt_q <= cnt_q + 4'h1;
        if (fin) begin
          busy_q     <= 1'b0;
          last_cyc_q <= elapsed_q + 8'h01;
        end
      end
    end
  end

  // Memory port registers and read capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
      for (int i = 0; i < 5; i++) cap_q[i] <= 8'h00;
    end else if (ce) begin
      if (completing) cap_q[step_q] <= mem_rdata;
      if (busy_q && !stall) begin
        mem_req_q   <= a_vld;
        mem_we_q    <= a_we;
        mem_addr_q  <= a_addr;
        mem_wdata_q <= a_wd;
      end
    end
  end

  // Command registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q      <= OP_CARRY_ONE;
      kind_q    <= KIND_ACC;
      bit_q     <= 3'h0;
      operand_q <= 16'h0000;
    end else if (ce && wr_fire && !busy_q) begin
      if (aw_addr_q == OFS_CMD) begin
        op_q   <= op_e'(wr_val[CMD_OP_LSB +: 4]);
        kind_q <= kind_e'(wr_val[CMD_KIND_LSB +: 3]);
        bit_q  <= wr_val[CMD_BIT_LSB +: 3];
      end
      if (aw_addr_q == OFS_OPERAND) operand_q <= wr_val[15:0];
    end
  end

  // Core state: software loads when idle, instructions commit at the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_counter_q <= COUNTER_RST;
      stack_pointer_q   <= STACK_RST;
      status_word_q     <= SW_RST;
      acc_q             <= 8'h00;
      pointer_pair_q    <= 16'h0000;
    end else if (ce) begin
      if (wr_fire && !busy_q) begin
        if (aw_addr_q == OFS_COUNTER) program_counter_q <= wr_val[15:0];
        if (aw_addr_q == OFS_STACK) stack_pointer_q <= wr_val[15:0];
        if (aw_addr_q == OFS_STATUS_WORD) status_word_q <= wr_val[7:0];
        if (aw_addr_q == OFS_ACC) acc_q <= wr_val[7:0];
        if (aw_addr_q == OFS_POINTER) pointer_pair_q <= wr_val[15:0];
      end
      if (fin) begin
        program_counter_q <= ret_addr;
        case (op_q)
          OP_BIT_AND: status_word_q[SW_CY_BIT] <= status_word_q[SW_CY_BIT] & src_bit; // RULE6
          OP_BIT_OR:  status_word_q[SW_CY_BIT] <= status_word_q[SW_CY_BIT] | src_bit; // RULE7
          OP_BIT_XOR: status_word_q[SW_CY_BIT] <= status_word_q[SW_CY_BIT] ^ src_bit; // RULE8
          OP_FORCE_ONE, OP_FORCE_ZERO: begin
            if (kind_q == KIND_ACC) acc_q[bit_q] <= (op_q == OP_FORCE_ONE);
            if (kind_q == KIND_STATUS_WORD) status_word_q[bit_q] <= (op_q == OP_FORCE_ONE); // RULE18
          end
          OP_CARRY_ONE:        status_word_q[SW_CY_BIT] <= 1'b1; // RULE18
          OP_CARRY_ZERO:       status_word_q[SW_CY_BIT] <= 1'b0;
          OP_CARRY_COMPLEMENT: status_word_q[SW_CY_BIT] <= ~status_word_q[SW_CY_BIT];
          OP_CALL: begin
            program_counter_q <= operand_q; // RULE13
            stack_pointer_q   <= stack_pointer_q - 16'h0002;
          end
          OP_FIXED_AREA_CALL: begin
            program_counter_q <= {FIXED_AREA_TOP, operand_q[10:0]}; // RULE14
            stack_pointer_q   <= stack_pointer_q - 16'h0002;
          end
          OP_TABLE_CALL: begin
            program_counter_q <= {cap_w[3], cap_w[2]}; // RULE15
            stack_pointer_q   <= stack_pointer_q - 16'h0002;
          end
          OP_SOFTWARE_BREAK: begin
            program_counter_q        <= {cap_w[3], cap_w[4]}; // RULE16
            stack_pointer_q          <= stack_pointer_q - 16'h0003;
            status_word_q[SW_IE_BIT] <= 1'b0;
          end
          OP_SUBROUTINE_RETURN: begin
            program_counter_q <= {cap_w[1], cap_w[0]}; // RULE17
            stack_pointer_q   <= stack_pointer_q + 16'h0002;
          end
          default: program_counter_q <= ret_addr;
        endcase
      end
    end
  end

  // ==========================================================================
  // Register read mux and byte-lane merge
  function automatic logic [31:0] reg_value(input logic [7:0] a, output logic ok);
    ok = 1'b1;
    if (a == OFS_CMD) reg_value = {21'h0, bit_q, 1'b0, kind_q, op_q};
    else if (a == OFS_OPERAND) reg_value = {16'h0000, operand_q};
    else if (a == OFS_COUNTER) reg_value = {16'h0000, program_counter_q};
    else if (a == OFS_STACK) reg_value = {16'h0000, stack_pointer_q};
    else if (a == OFS_STATUS_WORD) reg_value = {24'h000000, status_word_q};
    else if (a == OFS_ACC) reg_value = {24'h000000, acc_q};
    else if (a == OFS_POINTER) reg_value = {16'h0000, pointer_pair_q};
    else if (a == OFS_STATE) reg_value = {16'h0000, last_cyc_q, 7'h00, busy_q};
    else begin
      ok = 1'b0;
      reg_value = 32'h00000000;
    end
  endfunction

  always_comb begin
    wr_val = reg_value(aw_addr_q, wr_ok);
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) wr_val[8*b +: 8] = w_data_q[8*b +: 8];
    end
  end

  // AXI4-Lite write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready_q) begin
        aw_addr_q <= {awaddr[7:2], 2'b00};
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_q) begin
        logic ok;
        rdata_q   <= reg_value({araddr[7:2], 2'b00}, ok);
        rresp_q   <= ok ? RESP_OKAY : RESP_SLVERR;
        rvalid_q  <= 1'b1;
        arready_q <= 1'b0;
      end else if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Outputs
  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign mem_req   = mem_req_q;
  assign mem_we    = mem_we_q;
  assign mem_addr  = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign exec_busy = busy_q;

endmodule

// >>> verilog/bit_ops_call_return_pkg.sv
/*
  Constants, types and timing tables for the bit-logic and call/return execution block.
  Assumes a single 100 MHz clock; all counts are in CPU clock cycles.
*/
// Notes on behaviour
// RULE1: Every cycle figure is one CPU clock period; figures assume internal program memory.
// RULE2: Use the fast cycle count for high-speed RAM accesses or no data access.
// RULE3: Use the slow cycle count when the data access hits any other area.
// RULE4: Each read wait from expansion memory adds one cycle to the instruction.
// RULE5: Each write wait to expansion memory adds one cycle to the instruction.
// RULE6: Bit AND to carry: carry becomes carry AND chosen bit; other flags unchanged.
// RULE7: Bit OR to carry: carry becomes carry OR chosen bit, same operand kinds.
// RULE8: Bit XOR to carry: carry becomes carry XOR chosen bit, same operand kinds.
// RULE9: Pointer-pair carry logic: 2 bytes, 6 cycles fast, 7 plus read waits otherwise.
// RULE10: Accumulator form 2 bytes 4 cycles; sfr and status word forms 3 bytes 7 cycles.
// RULE11: Force-one writes 1 to pointer-pair bit; 2 bytes, 6 or 8 plus waits, RMW.
// RULE12: Force-zero writes 0 to pointer-pair bit; 2 bytes, 6 or 8 plus waits.
// RULE13: Call pushes next address high at stack-1, low at stack-2; 3 bytes 7 cycles.
// RULE14: Fixed-area call pushes address plus two, target 00001 and 11 bits; 5 cycles.
// RULE15: Table call pushes address plus one, loads target from table entry pair; 6 cycles.
// RULE16: Break pushes status word then return address, clears interrupt enable, vectors.
// RULE17: Return pops low byte then high byte into counter, stack rises by two; 6 cycles.
// RULE18: Status word bit forms change flags as written; carry ops change only carry.
// RULE19: Expansion memory may insert read and write waits; the core waits for them.
package bit_ops_call_return_pkg;

  // ==========================================================================
  // Operations and operand kinds
  typedef enum logic [3:0] {
    OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_FORCE_ONE, OP_FORCE_ZERO,
    OP_CARRY_ONE, OP_CARRY_ZERO, OP_CARRY_COMPLEMENT, OP_CALL,
    OP_FIXED_AREA_CALL, OP_TABLE_CALL, OP_SOFTWARE_BREAK, OP_SUBROUTINE_RETURN
  } op_e;

  typedef enum logic [2:0] {
    KIND_SHORT_DIRECT, KIND_SFR, KIND_ACC, KIND_STATUS_WORD, KIND_POINTER_PAIR
  } kind_e;

  // ==========================================================================
  // Register offsets (byte addresses) and fields
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_STACK   = 8'h0C;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h10;
  localparam logic [7:0] OFS_ACC     = 8'h14;
  localparam logic [7:0] OFS_POINTER = 8'h18;
  localparam logic [7:0] OFS_STATE   = 8'h1C;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_KIND_LSB = 4;
  localparam int CMD_BIT_LSB  = 8;
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_CYC_LSB  = 8;
  localparam int SW_IE_BIT = 7;
  localparam int SW_CY_BIT = 0;

  // ==========================================================================
  // Reset values, fixed addresses and memory areas
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [15:0] STACK_RST   = 16'hFEE0;
  localparam logic [7:0]  SW_RST      = 8'h00;
  localparam logic [15:0] VEC_HIGH_ADDR = 16'h003F;
  localparam logic [15:0] VEC_LOW_ADDR  = 16'h003E;
  localparam logic [4:0]  FIXED_AREA_TOP = 5'h01;
  localparam logic [15:0] HS_RAM_LO = 16'hFB00;
  localparam logic [15:0] HS_RAM_HI = 16'hFEFF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Cycle counts
  localparam logic [3:0] CYC_LOG_HS       = 4'h6;
  localparam logic [3:0] CYC_LOG_EXT      = 4'h7;
  localparam logic [3:0] CYC_ACC          = 4'h4;
  localparam logic [3:0] CYC_FRC_SHORT_HS = 4'h4;
  localparam logic [3:0] CYC_FRC_SHORT_EX = 4'h6;
  localparam logic [3:0] CYC_FRC_SFR      = 4'h8;
  localparam logic [3:0] CYC_FRC_SW       = 4'h6;
  localparam logic [3:0] CYC_FRC_PTR_HS   = 4'h6;
  localparam logic [3:0] CYC_FRC_PTR_EX   = 4'h8;
  localparam logic [3:0] CYC_CARRY        = 4'h2;
  localparam logic [3:0] CYC_CALL         = 4'h7;
  localparam logic [3:0] CYC_FIXED_CALL   = 4'h5;
  localparam logic [3:0] CYC_TABLE_CALL   = 4'h6;
  localparam logic [3:0] CYC_BREAK        = 4'h6;
  localparam logic [3:0] CYC_RETURN       = 4'h6;
  localparam logic [3:0] CYC_OTHER        = 4'h1;

  // ==========================================================================
  // Instruction lengths in bytes
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;

endpackage

// >>> verif/bit_ops_call_return_chk.sv
/*
  Port checker for the exec block.
  Bound from the bench top; one clock, reset low.
*/
`timescale 1ns/1ps
module bit_ops_call_return_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  // Memory port and status
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rdy,
  input wire logic        exec_busy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] busy_q;
  // ==========
  // Busy run length
  always_ff @(posedge aclk) begin
    if (!aresetn || !exec_busy) busy_q <= 6'h00;
    else busy_q <= busy_q + 6'h01;
  end
  // ==========
  // Properties
  property p_wr_resp; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_wr_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_wr_done: assert property (p_wr_done) else $error("write stuck");
  property p_rd_resp; arvalid && arready |=> rvalid && !arready; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_rd_done; rvalid && rready |=> !rvalid; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read stuck");
  property p_req_hold; mem_req && !mem_rdy |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("access dropped");
  property p_wait_busy; mem_req && !mem_rdy |=> exec_busy; endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("wait ended instr");
  property p_req_busy; mem_req |-> exec_busy; endproperty
  a_req_busy: assert property (p_req_busy) else $error("access while idle");
  property p_busy_len; busy_q < 6'h14; endproperty
  a_busy_len: assert property (p_busy_len) else $error("instr too long");
endmodule

// >>> verif/exec_mem_model.sv
/*
  Memory behind the exec block's data port.
  Waits only outside the fast RAM window.
*/
`timescale 1ns/1ps
module exec_mem_model
  import bit_ops_call_return_pkg::*;
(
  // Core side
  input  wire logic        aclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  // Wait count from bench
  input  wire logic [3:0]  waits,
  // Answers
  output logic [7:0]       mem_rdata,
  output logic             mem_rdy
);
  logic [7:0] m [0:65535];
  logic [7:0] last_q = 8'h00;
  logic [3:0] cnt_q  = 4'h0;
  logic       ext;
  // Slow area gets waits; stale data inverted
  assign ext       = mem_addr < HS_RAM_LO || mem_addr > HS_RAM_HI;
  assign mem_rdy   = mem_req && (!ext || cnt_q == waits);
  assign mem_rdata = mem_rdy ? m[mem_addr] : ~last_q;
  // Count waits, store writes
  always @(posedge aclk) begin
    cnt_q <= (mem_req && !mem_rdy) ? cnt_q + 4'h1 : 4'h0;
    if (mem_rdy && mem_we) m[mem_addr] <= mem_wdata;
    if (mem_rdy) last_q <= m[mem_addr];
  end
endmodule

// >>> verif/bit_ops_call_return_exec_tb.sv
/*
  Exec block bench: bus tasks, memory model, scenarios.
  Assumes package, model and checker compiled first.
*/
`timescale 1ns/1ps
module bit_ops_call_return_exec_tb;
  import bit_ops_call_return_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_q;
  logic [3:0]  waits = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_rdy, exec_busy;
  logic [1:0]  bresp, rresp, rsp_q;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  // ==========
  // Clock, timeout, instances
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      print_verdict;
    end
  end
  bit_ops_call_return_exec u_bit_ops_call_return_exec (.aclk, .aresetn, .ce(1'b1),
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_rdy, .exec_busy);
  exec_mem_model u_exec_mem_model (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .waits, .mem_rdata, .mem_rdy);
  // ==========
  // Bus and check tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_q = rdata;
    rsp_q = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_q, e);
  endtask
  function automatic logic [31:0] mb(input logic [15:0] a);
    return {24'h0, u_exec_mem_model.m[a]};
  endfunction
  task automatic run(input logic [3:0] op, input logic [2:0] kind, input logic [2:0] bn,
                     input logic [15:0] opr, input logic [15:0] pc);
    wr(OFS_OPERAND, {16'h0, opr});
    wr(OFS_COUNTER, {16'h0, pc});
    wr(OFS_CMD, {21'h0, bn, 1'b0, kind, op});
    do @(posedge aclk); while (exec_busy);
  endtask
  // ==========
  // Scenarios
  task automatic t_call;
    rchk(OFS_STACK, 32'hFEE0);
    rd(8'h40);
    chk({30'h0, rsp_q}, {30'h0, RESP_SLVERR});
    run(4'h8, 3'h0, 3'h0, 16'h1234, 16'h0100);
    rchk(OFS_COUNTER, 32'h1234);
    rchk(OFS_STACK, 32'hFEDE);
    chk(mb(16'hFEDF), 32'h01);
    chk(mb(16'hFEDE), 32'h03);
    rchk(OFS_STATE, 32'h0700);
    run(4'hC, 3'h0, 3'h0, 16'h0, 16'h5555);
    rchk(OFS_COUNTER, 32'h0103);
    rchk(OFS_STACK, 32'hFEE0);
    rchk(OFS_STATE, 32'h0600);
    run(4'h9, 3'h0, 3'h0, 16'h0123, 16'h0200);
    rchk(OFS_COUNTER, 32'h0923);
    chk(mb(16'hFEDE), 32'h02);
    rchk(OFS_STATE, 32'h0500);
  endtask
  task automatic t_brk;
    wr(OFS_STATUS_WORD, 32'h81);
    u_exec_mem_model.m[16'h003F] = 8'h56;
    u_exec_mem_model.m[16'h003E] = 8'h78;
    run(4'hB, 3'h0, 3'h0, 16'h0, 16'h0400);
    rchk(OFS_COUNTER, 32'h5678);
    rchk(OFS_STATUS_WORD, 32'h01);
    rchk(OFS_STACK, 32'hFEDB);
    chk(mb(16'hFEDD), 32'h81);
    chk(mb(16'hFEDB), 32'h01);
    rchk(OFS_STATE, 32'h0600);
    u_exec_mem_model.m[16'h0005] = 8'h34;
    u_exec_mem_model.m[16'h0006] = 8'h12;
    run(4'hA, 3'h0, 3'h0, 16'h0005, 16'h0);
    rchk(OFS_COUNTER, 32'h1234);
  endtask
  task automatic t_bits;
    wr(OFS_POINTER, 32'h1000);
    wr(OFS_STATUS_WORD, 32'h0);
    waits <= 4'h2;
    u_exec_mem_model.m[16'h1000] = 8'h08;
    for (int i = 0; i < 3; i++) begin
      run(4'(i), 3'h4, 3'h3, 16'h0, 16'h0);
      rchk(OFS_STATUS_WORD, {31'h0, i == 1});
      rchk(OFS_STATE, 32'h0900);
    end
    wr(OFS_ACC, 32'h01);
    run(4'h1, 3'h2, 3'h0, 16'h0, 16'h0);
    rchk(OFS_STATE, 32'h0400);
    run(4'h3, 3'h4, 3'h0, 16'h0, 16'h0);
    chk(mb(16'h1000), 32'h09);
    rchk(OFS_STATE, 32'h0C00);
    run(4'h4, 3'h4, 3'h3, 16'h0, 16'h0);
    chk(mb(16'h1000), 32'h01);
    run(4'h7, 3'h0, 3'h0, 16'h0, 16'h0);
    rchk(OFS_STATUS_WORD, 32'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_call;
    t_brk;
    t_bits;
    print_verdict;
  end
endmodule
bind bit_ops_call_return_exec bit_ops_call_return_chk u_bit_ops_call_return_chk (.*);
